//--- hdl/fault_seq_pkg.sv
// Purpose: Shared constants for the converter fault sequencer
// Assumes: 20 MHz system clock, classic Wishbone register access
// Notes: Times are kept in microseconds; cycle counts derive from them
package fault_seq_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CNT_W = 24;

	// Round a time in microseconds up to whole clock cycles, at least one
	function automatic int unsigned us_to_cyc(input int unsigned us);
		longint unsigned c;
		c = (longint'(us) * CLK_HZ + 999_999) / 1_000_000;
		return (c == 0) ? 1 : int'(c);
	endfunction

	// Documented hold-off before current limiting acts
	localparam int unsigned CL_HOLDOFF_US = 1000;
	// Nominal current-limit threshold, percent of rated current
	localparam int unsigned CL_NOM_PCT = 120;
	// Delays with no printed value: plain defaults
	localparam int unsigned INIT_US = 1000;
	localparam int unsigned STARTUP_US = 500;
	localparam int unsigned DWELL_US = 10000;
	localparam int unsigned BROWNOUT_US = 100;
	localparam int unsigned SURGE_US = 100;
	localparam int unsigned IND_PULSE_US = 100;
	localparam int unsigned BROWNOUT_CYC = us_to_cyc(BROWNOUT_US);
	localparam int unsigned SURGE_CYC = us_to_cyc(SURGE_US);
	localparam int unsigned IND_PULSE_CYC = us_to_cyc(IND_PULSE_US);

	// Register byte offsets
	localparam logic [3:0] CTRL_ADR = 4'h0;
	localparam logic [3:0] STATUS_ADR = 4'h4;
	localparam logic [3:0] CAUSE_ADR = 4'h8;
	// Control fields
	localparam int CTRL_SOFT_EN = 0;
	localparam logic CTRL_RST = 1'h1;
	// Cause bit positions
	localparam int CAUSE_IN_LOW = 0;
	localparam int CAUSE_IN_HIGH = 1;
	localparam int CAUSE_OUT_LOW = 2;
	localparam int CAUSE_OVER_TEMP = 3;
	localparam int CAUSE_OUT_HIGH = 4;
	localparam int CAUSE_W = 5;

	// Sequencer states, Gray coded in listed order; one bit per step along the start path
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_SETTLE = 3'h1,
		ST_STARTUP = 3'h3,
		ST_SOFT = 3'h2,
		ST_RUN = 3'h6,
		ST_DWELL = 3'h7,
		ST_WAIT_IN = 3'h5,
		ST_LATCHED = 3'h4
	} seq_state_t;
endpackage

//--- hdl/persist_filter.sv
// Purpose: Passes a flag only after it has held high for a set time
// Assumes: Input already synchronised to clk_i
// Notes: Output drops in the cycle after the input falls
`timescale 1ns/10ps
module persist_filter #(
	parameter int unsigned HOLD_CYC = 1
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, high
	input wire logic flag_i, // Raw level
	output logic flag_o // Level held long enough
);
	import fault_seq_pkg::*;

	logic [CNT_W-1:0] cnt;
	wire hold_done = (cnt >= CNT_W'(HOLD_CYC - 1));

	// Count the run of high samples
	always_ff @(posedge clk_i) begin
		if (rst_i || !flag_i) begin
			cnt <= '0;
			flag_o <= 1'b0;
		end else begin
			if (!hold_done)
				cnt <= cnt + CNT_W'(1);
			flag_o <= hold_done;
		end
	end
endmodule

//--- hdl/converter_fault_sequencer.sv
// Purpose: Fault protection and restart sequencing for an isolated converter
// Assumes: Comparator flags arrive as digital levels from outside this clock
// Notes: rst_i stands for the power-on reset raised when input is applied
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// - When off, ignore turn-on until input rises above upper low-lockout level.
// - Running with input below lower low-lockout level: record fault, stop switching.
// - Input dips shorter than the brownout filter time are ignored.
// - After input-low fault, stay off until input recovers, restart if requested.
// - Input above upper high-lockout level: record fault, stop switching.
// - After input-high fault, stay off until input falls below lower level.
// - Fast overvoltage halts switching at once; brief events leave no fault.
// - Input-high persisting past the surge filter time is a fault when off, starting or running.
// - Running after soft start with output below low threshold: short-circuit fault, stop at once.
// - After output-low fault, hold off dwell time, then settle and startup delays.
// - Internal temperature over limit: record fault, stop switching at once.
// - After over-temperature, wait dwell and cool-down, then settle and startup.
// - Each switching cycle compare output with high threshold, disable if over.
// - Output-high fault latches; cleared by turn-on low or input below clear level.
// - Current-limit action waits one millisecond after current first exceeds threshold.
// - Limit threshold nominally 120 percent, reduced when trimmed above nominal.
// - Limiting may pull output to low threshold; further overload trips output-low.
// - Sustained current limiting trips no fault and needs no derating.
// - Fault indicator is active whenever the powertrain is stopped.
// - Fault indicator pulses briefly at the start of soft start.
// - Trim mode latched at power application survives every fault and disable.
module converter_fault_sequencer #(
	parameter int unsigned INIT_CYC = fault_seq_pkg::us_to_cyc(fault_seq_pkg::INIT_US),
	parameter int unsigned STARTUP_CYC = fault_seq_pkg::us_to_cyc(fault_seq_pkg::STARTUP_US),
	parameter int unsigned DWELL_CYC = fault_seq_pkg::us_to_cyc(fault_seq_pkg::DWELL_US),
	parameter int unsigned CL_HOLDOFF_CYC = fault_seq_pkg::us_to_cyc(fault_seq_pkg::CL_HOLDOFF_US)
) (
	input wire logic clk_i, // System clock, 20 MHz
	input wire logic rst_i, // Synchronous reset, high
	input wire logic enable_pin_i, // Turn-on request from the system
	input wire logic in_above_low_hi_i, // Input above upper low-lockout level
	input wire logic in_below_low_lo_i, // Input below lower low-lockout level
	input wire logic in_above_high_hi_i, // Input above upper high-lockout level
	input wire logic in_below_high_lo_i, // Input below lower high-lockout level
	input wire logic in_below_clear_i, // Input below latch-clear level
	input wire logic fast_in_high_i, // Fast input overvoltage from controller
	input wire logic out_below_low_i, // Output below low threshold
	input wire logic out_above_high_i, // Output above high threshold
	input wire logic over_temp_i, // Internal temperature above limit
	input wire logic iout_over_limit_i, // Output current above limit threshold
	input wire logic trim_above_nom_i, // Output trimmed above nominal
	input wire logic adjust_pin_low_i, // Output adjust pin sampled low
	input wire logic ramp_done_i, // Soft-start ramp finished
	input wire logic cycle_tick_i, // One pulse per switching cycle, same clock
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [3:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	output logic powertrain_run_o, // Powertrain switching allowed
	output logic soft_start_o, // Soft-start ramp in progress
	output logic fault_indicator_o, // Fault indicator pin level
	output logic current_limit_o, // Current limiting active
	output logic cl_reduced_o, // Use reduced current-limit threshold
	output logic trim_active_o // Trim mode latched on
);
	import fault_seq_pkg::*;

	localparam int SYNC_W = 14;

	// Two-flop synchronisers for every pin flag
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	wire [SYNC_W-1:0] raw_flags = {enable_pin_i, in_above_low_hi_i, in_below_low_lo_i,
		in_above_high_hi_i, in_below_high_lo_i, in_below_clear_i, fast_in_high_i,
		out_below_low_i, out_above_high_i, over_temp_i, iout_over_limit_i,
		trim_above_nom_i, adjust_pin_low_i, ramp_done_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= raw_flags;
			sync2 <= sync1;
		end
	end

	// Synchronised flag names
	wire en_pin = sync2[13];
	wire in_ok_hi = sync2[12];
	wire in_low = sync2[11];
	wire in_high = sync2[10];
	wire in_high_clear = sync2[9];
	wire in_clear = sync2[8];
	wire fast_high = sync2[7];
	wire out_low = sync2[6];
	wire out_high = sync2[5];
	wire hot = sync2[4];
	wire iout_over = sync2[3];
	wire trim_high = sync2[2];
	wire adj_low = sync2[1];
	wire ramp_done = sync2[0];

	// Filtered input faults
	logic in_low_conf;
	logic in_high_conf;

	// Brownout filter on the low-input flag
	persist_filter #(
		.HOLD_CYC(BROWNOUT_CYC)
	) u_brownout (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flag_i(in_low),
		.flag_o(in_low_conf)
	);

	// Surge filter on the high-input flag
	persist_filter #(
		.HOLD_CYC(SURGE_CYC)
	) u_surge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flag_i(in_high),
		.flag_o(in_high_conf)
	);

	// Control register and derived turn-on request
	logic soft_en;
	wire turn_on = en_pin & soft_en;

	seq_state_t state;
	seq_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CAUSE_W-1:0] cause;
	logic [CAUSE_W-1:0] fault_set;
	logic [CAUSE_W-1:0] next_cause;
	logic dwell_for_temp;
	logic trim_latched;
	logic trim_mode;
	logic [CNT_W-1:0] cl_cnt;

	// Timer compare helper
	function automatic logic elapsed(input logic [CNT_W-1:0] c, input int unsigned n);
		return c >= CNT_W'(n - 1);
	endfunction

	wire switching_state = (state == ST_SOFT) || (state == ST_RUN);
	wire fast_halt = fast_high | in_high;
	wire cycle_high = cycle_tick_i & out_high;
	wire start_ok = turn_on & in_ok_hi & ~in_high;
	wire init_done = elapsed(cnt, INIT_CYC);
	wire startup_done = elapsed(cnt, STARTUP_CYC);
	wire dwell_done = elapsed(cnt, DWELL_CYC);
	wire pulse_on = !elapsed(cnt, IND_PULSE_CYC);
	wire latch_clear = ~turn_on | in_clear;

	// Next-state logic; the output-high latch is checked first
	always_comb begin
		next_state = state;
		fault_set = '0;
		case (state)
			ST_OFF: begin
				if (in_high_conf) begin
					fault_set[CAUSE_IN_HIGH] = 1'b1;
					next_state = ST_WAIT_IN;
				end else if (start_ok) begin
					next_state = ST_SETTLE;
				end
			end
			ST_SETTLE, ST_STARTUP: begin
				if (in_high_conf) begin
					fault_set[CAUSE_IN_HIGH] = 1'b1;
					next_state = ST_WAIT_IN;
				end else if (!turn_on || in_low_conf) begin
					next_state = ST_OFF;
				end else if (state == ST_SETTLE && init_done) begin
					next_state = ST_STARTUP;
				end else if (state == ST_STARTUP && startup_done) begin
					next_state = ST_SOFT;
				end
			end
			ST_SOFT, ST_RUN: begin
				if (cycle_high) begin
					fault_set[CAUSE_OUT_HIGH] = 1'b1;
					next_state = ST_LATCHED;
				end else if (hot) begin
					fault_set[CAUSE_OVER_TEMP] = 1'b1;
					next_state = ST_DWELL;
				end else if (state == ST_RUN && out_low) begin
					fault_set[CAUSE_OUT_LOW] = 1'b1;
					next_state = ST_DWELL;
				end else if (in_high_conf) begin
					fault_set[CAUSE_IN_HIGH] = 1'b1;
					next_state = ST_WAIT_IN;
				end else if (in_low_conf) begin
					fault_set[CAUSE_IN_LOW] = 1'b1;
					next_state = ST_WAIT_IN;
				end else if (!turn_on) begin
					next_state = ST_OFF;
				end else if (state == ST_SOFT && ramp_done) begin
					next_state = ST_RUN;
				end
			end
			ST_DWELL: begin
				// Hold off, and for heat also wait for cool-down
				if (dwell_done && !(dwell_for_temp && hot))
					next_state = turn_on ? ST_SETTLE : ST_OFF;
			end
			ST_WAIT_IN: begin
				// Input recovery before any restart
				if (in_ok_hi && in_high_clear && !in_high)
					next_state = ST_OFF;
			end
			ST_LATCHED: begin
				if (latch_clear)
					next_state = ST_OFF;
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
	end

	// Sequencer state and shared delay counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_OFF;
			cnt <= '0;
		end else begin
			state <= next_state;
			if (next_state != state)
				cnt <= '0;
			else if (!(&cnt))
				cnt <= cnt + CNT_W'(1);
		end
	end

	// Remember whether the dwell also waits on temperature
	always_ff @(posedge clk_i) begin
		if (rst_i)
			dwell_for_temp <= 1'b0;
		else if (next_state == ST_DWELL && state != ST_DWELL)
			dwell_for_temp <= fault_set[CAUSE_OVER_TEMP];
	end

	// Trim mode caught once, when input first rises above lockout
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trim_latched <= 1'b0;
			trim_mode <= 1'b0;
		end else if (!trim_latched && in_ok_hi) begin
			trim_latched <= 1'b1;
			trim_mode <= adj_low;
		end
	end

	// Current-limit hold-off while switching
	wire cl_reached = elapsed(cl_cnt, CL_HOLDOFF_CYC);
	always_ff @(posedge clk_i) begin
		if (rst_i || !iout_over || !switching_state)
			cl_cnt <= '0;
		else if (!cl_reached)
			cl_cnt <= cl_cnt + CNT_W'(1);
	end

	// Registered pin outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			powertrain_run_o <= 1'b0;
			soft_start_o <= 1'b0;
			fault_indicator_o <= 1'b1;
			current_limit_o <= 1'b0;
			cl_reduced_o <= 1'b0;
		end else begin
			powertrain_run_o <= switching_state & ~fast_halt;
			soft_start_o <= (state == ST_SOFT);
			fault_indicator_o <= ~switching_state | fast_halt
				| ((state == ST_SOFT) & pulse_on);
			current_limit_o <= switching_state & iout_over & cl_reached;
			cl_reduced_o <= trim_mode & trim_high;
		end
	end
	assign trim_active_o = trim_mode;

	// Wishbone decode
	wire wb_req = wb_cyc_i & wb_stb_i;
	wire sel_ctrl = (wb_adr_i == CTRL_ADR);
	wire sel_status = (wb_adr_i == STATUS_ADR);
	wire sel_cause = (wb_adr_i == CAUSE_ADR);
	wire wr_take = wb_req & ~wb_ack_o & wb_we_i & wb_sel_i[0];
	wire [CAUSE_W-1:0] cause_clr = (wr_take & sel_cause) ? wb_dat_i[CAUSE_W-1:0] : '0;
	wire [31:0] status_word = {24'h0, fault_indicator_o, powertrain_run_o,
		current_limit_o, (state == ST_LATCHED), trim_mode, state};
	wire [31:0] rd_word = sel_ctrl ? {31'h0, soft_en}
		: sel_status ? status_word
		: sel_cause ? {{(32 - CAUSE_W){1'b0}}, cause}
		: 32'h0;

	// Sticky causes: a new fault wins over a clear
	assign next_cause = (cause & ~cause_clr) | fault_set;

	// Register writes and the one-cycle acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			soft_en <= CTRL_RST;
			cause <= '0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			cause <= next_cause;
			wb_ack_o <= wb_req & ~wb_ack_o;
			wb_dat_o <= (wb_req & ~wb_ack_o) ? rd_word : 32'h0;
			if (wr_take && sel_ctrl)
				soft_en <= wb_dat_i[CTRL_SOFT_EN];
		end
	end
endmodule

//--- verif/converter_fault_sequencer_sva.sv
// Purpose: Concurrent checks on the fault sequencer ports
// Assumes: Flag inputs reach the logic two edges after a pin change
// Notes: Bound into the sequencer from the bench top file
`timescale 1ns/10ps
module converter_fault_sequencer_sva #(
	parameter int unsigned CL_HOLDOFF_CYC = 16
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic enable_pin_i, // Turn-on request
	input wire logic fast_in_high_i, // Fast input high
	input wire logic out_below_low_i, // Output low
	input wire logic out_above_high_i, // Output high
	input wire logic over_temp_i, // Over temperature
	input wire logic iout_over_limit_i, // Overload
	input wire logic cycle_tick_i, // Switching tick
	input wire logic powertrain_run_o, // Switching allowed
	input wire logic soft_start_o, // Ramp running
	input wire logic fault_indicator_o, // Indicator
	input wire logic current_limit_o // Limiting
);
	logic [7:0] ovl_cnt;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Cycles of overload while switching
	always_ff @(posedge clk_i) begin
		if (rst_i || !iout_over_limit_i || !powertrain_run_o)
			ovl_cnt <= 8'h0;
		else if (ovl_cnt != 8'hff)
			ovl_cnt <= ovl_cnt + 8'h1;
	end
	idle_ind_a: assert property (!powertrain_run_o |-> fault_indicator_o)
		else $error("indicator low while stopped");
	disable_stop_a: assert property (!enable_pin_i [*6] |-> !powertrain_run_o)
		else $error("switching without turn-on");
	fast_halt_a: assert property (fast_in_high_i [*5] |-> !powertrain_run_o)
		else $error("fast halt missed");
	temp_stop_a: assert property (over_temp_i [*5] |-> !powertrain_run_o)
		else $error("over temperature missed");
	short_stop_a: assert property (!soft_start_o throughout out_below_low_i [*5] |-> !powertrain_run_o)
		else $error("output low missed");
	ovp_stop_a: assert property (out_above_high_i [*5] ##0 cycle_tick_i |=> ##[0:2] !powertrain_run_o)
		else $error("output high missed");
	cl_hold_a: assert property (ovl_cnt > 0 && ovl_cnt < CL_HOLDOFF_CYC |-> !current_limit_o)
		else $error("limit acted early");
	cl_act_a: assert property (ovl_cnt == CL_HOLDOFF_CYC + 8 |-> current_limit_o)
		else $error("limit never acted");
	cl_nofault_a: assert property ($rose(current_limit_o) |=> powertrain_run_o [*8])
		else $error("limiting stopped switching");
	start_ind_a: assert property ($rose(soft_start_o) |-> fault_indicator_o)
		else $error("no indicator at start");
endmodule

//--- verif/system_ctrl_model.sv
// Purpose: System controller that drives turn-on and watches the indicator
// Assumes: Bench calls set_on between clock edges
// Notes: Changes its request only just after a rising edge
`timescale 1ns/10ps
module system_ctrl_model (
	input wire logic clk_i, // Clock
	input wire logic fault_indicator_i, // Indicator from block
	output logic enable_o // Turn-on request
);
	int fault_cycles;
	initial enable_o = 1'b0;
	// Length of the current indicator episode
	always @(posedge clk_i) fault_cycles <= fault_indicator_i ? fault_cycles + 1 : 0;
	// Request change; dropping it clears a latched fault
	task automatic set_on(input logic v);
		@(posedge clk_i);
		enable_o <= v;
	endtask
endmodule

//--- verif/converter_fault_sequencer_tb.sv
// Purpose: Self-checking bench for the converter fault sequencer
// Assumes: Shortened delay parameters; flags driven as clean levels
// Notes: Filter and indicator times stay at 2000 cycles
`timescale 1ns/10ps
module converter_fault_sequencer_tb;
	import fault_seq_pkg::*;
	localparam int unsigned CLH = 16;
	logic clk_i, rst_i, in_above_low_hi_i, in_below_low_lo_i, in_above_high_hi_i, in_below_high_lo_i;
	logic in_below_clear_i, fast_in_high_i, out_below_low_i, out_above_high_i, over_temp_i, ramp_done_i;
	logic iout_over_limit_i, trim_above_nom_i, adjust_pin_low_i, cycle_tick_i, wb_cyc_i, wb_stb_i, wb_we_i;
	logic wb_ack_o, powertrain_run_o, soft_start_o, fault_indicator_o, current_limit_o, cl_reduced_o;
	logic trim_active_o;
	wire enable_pin_i;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [1:0] tick_n;
	int mismatches, checks, n;
	converter_fault_sequencer #(.INIT_CYC(8), .STARTUP_CYC(8), .DWELL_CYC(16), .CL_HOLDOFF_CYC(CLH))
		converter_fault_sequencer_inst (.clk_i, .rst_i, .enable_pin_i, .in_above_low_hi_i, .in_below_low_lo_i,
		.in_above_high_hi_i, .in_below_high_lo_i, .in_below_clear_i, .fast_in_high_i, .out_below_low_i,
		.out_above_high_i, .over_temp_i, .iout_over_limit_i, .trim_above_nom_i, .adjust_pin_low_i, .ramp_done_i,
		.cycle_tick_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.powertrain_run_o, .soft_start_o, .fault_indicator_o, .current_limit_o, .cl_reduced_o, .trim_active_o);
	system_ctrl_model system_ctrl_model_inst (.clk_i, .fault_indicator_i(fault_indicator_o), .enable_o(enable_pin_i));
	// Clock and switching tick
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		tick_n <= tick_n + 2'h1;
		cycle_tick_i <= (tick_n == 2'h3);
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		test_done();
	end
	task automatic test_done();
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic single Wishbone cycle, held until ack is sampled
	task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		check(k < 20, 1'b1);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, q);
		check(q, e);
	endtask
	// Wait for switching to reach a level, counting cycles
	task automatic wait_run(input logic v, input int lim, output int c);
		c = 0;
		while (powertrain_run_o !== v && c < lim) begin
			@(posedge clk_i);
			c++;
		end
		check(powertrain_run_o, v);
	endtask
	task automatic trip(input int t);
		repeat (t) @(posedge clk_i);
	endtask
	initial begin
		rst_i = 1'b1;
		{in_above_low_hi_i, in_below_low_lo_i, in_above_high_hi_i, in_below_clear_i, fast_in_high_i} = 5'h0;
		{out_below_low_i, out_above_high_i, over_temp_i, iout_over_limit_i, ramp_done_i} = 5'h0;
		{in_below_high_lo_i, trim_above_nom_i, adjust_pin_low_i} = 3'h7;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 39'h0;
		wb_sel_i = 4'hf;
		tick_n = 2'h0;
		cycle_tick_i = 1'b0;
		trip(4);
		rst_i <= 1'b0;
		system_ctrl_model_inst.set_on(1'b1);
		trip(40);
		check(powertrain_run_o, 1'b0);
		rd_chk(CTRL_ADR, 32'h1);
		rd_chk(4'hc, 32'h0);
		wb_sel_i <= 4'h0;
		xfer(1'b1, CTRL_ADR, 32'h0, q);
		wb_sel_i <= 4'hf;
		rd_chk(CTRL_ADR, 32'h1);
		in_above_low_hi_i <= 1'b1;
		wait_run(1'b1, 100, n);
		check({soft_start_o, fault_indicator_o, trim_active_o, cl_reduced_o}, 4'hf);
		// Trim mode must stay caught; reduced limit follows the trim level
		trim_above_nom_i <= 1'b0;
		adjust_pin_low_i <= 1'b0;
		trip(5);
		check({cl_reduced_o, trim_active_o}, 2'h1);
		ramp_done_i <= 1'b1;
		trip(2100);
		check(fault_indicator_o, 1'b0);
		iout_over_limit_i <= 1'b1;
		trip(CLH + 20);
		check({current_limit_o, powertrain_run_o}, 2'h3);
		iout_over_limit_i <= 1'b0;
		in_below_low_lo_i <= 1'b1;
		trip(100);
		in_below_low_lo_i <= 1'b0;
		trip(10);
		check(powertrain_run_o, 1'b1);
		rd_chk(CAUSE_ADR, 32'h0);
		in_below_low_lo_i <= 1'b1;
		in_above_low_hi_i <= 1'b0;
		wait_run(1'b0, 2100, n);
		rd_chk(CAUSE_ADR, 32'h1 << CAUSE_IN_LOW);
		in_below_low_lo_i <= 1'b0;
		trip(40);
		check(powertrain_run_o, 1'b0);
		in_above_low_hi_i <= 1'b1;
		wait_run(1'b1, 100, n);
		xfer(1'b1, CAUSE_ADR, 32'h1f, q);
		fast_in_high_i <= 1'b1;
		trip(10);
		check(powertrain_run_o, 1'b0);
		fast_in_high_i <= 1'b0;
		trip(10);
		check(powertrain_run_o, 1'b1);
		rd_chk(CAUSE_ADR, 32'h0);
		in_above_high_hi_i <= 1'b1;
		in_below_high_lo_i <= 1'b0;
		trip(2100);
		rd_chk(CAUSE_ADR, 32'h1 << CAUSE_IN_HIGH);
		in_above_high_hi_i <= 1'b0;
		trip(40);
		check(powertrain_run_o, 1'b0);
		in_below_high_lo_i <= 1'b1;
		wait_run(1'b1, 100, n);
		xfer(1'b1, CAUSE_ADR, 32'h1f, q);
		over_temp_i <= 1'b1;
		wait_run(1'b0, 10, n);
		trip(60);
		check(powertrain_run_o, 1'b0);
		over_temp_i <= 1'b0;
		wait_run(1'b1, 100, n);
		rd_chk(CAUSE_ADR, 32'h1 << CAUSE_OVER_TEMP);
		trip(10);
		out_below_low_i <= 1'b1;
		wait_run(1'b0, 10, n);
		out_below_low_i <= 1'b0;
		wait_run(1'b1, 100, n);
		check(n >= 32, 1'b1);
		trip(10);
		out_above_high_i <= 1'b1;
		wait_run(1'b0, 20, n);
		{out_above_high_i, over_temp_i} <= 2'h1;
		trip(60);
		over_temp_i <= 1'b0;
		trip(60);
		check(powertrain_run_o, 1'b0);
		rd_chk(STATUS_ADR, 32'h9c);
		system_ctrl_model_inst.set_on(1'b0);
		trip(10);
		system_ctrl_model_inst.set_on(1'b1);
		wait_run(1'b1, 100, n);
		trip(10);
		out_above_high_i <= 1'b1;
		wait_run(1'b0, 20, n);
		{out_above_high_i, in_below_clear_i} <= 2'h1;
		trip(10);
		in_below_clear_i <= 1'b0;
		wait_run(1'b1, 100, n);
		system_ctrl_model_inst.set_on(1'b0);
		wait_run(1'b0, 10, n);
		check(fault_indicator_o, 1'b1);
		test_done();
	end
endmodule
bind converter_fault_sequencer converter_fault_sequencer_sva #(.CL_HOLDOFF_CYC(CL_HOLDOFF_CYC)) sva_inst (.clk_i,
	.rst_i, .enable_pin_i, .fast_in_high_i, .out_below_low_i, .out_above_high_i, .over_temp_i, .iout_over_limit_i,
	.cycle_tick_i, .powertrain_run_o, .soft_start_o, .fault_indicator_o, .current_limit_o);
